// *** rtl/tms_pkg.sv ***
// tms_pkg: constants and types of the transceiver management slave
// assumes a 100 MHz system clock and a host-owned two-wire serial link
package tms_pkg;

   // =====================================================================
   // serial addresses and map layout
   localparam logic [6:0] TMS_ID_DEV_ADDR   = 7'h50;
   localparam logic [6:0] TMS_DIAG_DEV_ADDR = 7'h51;
   localparam int         TMS_MAP_BYTES     = 256;
   localparam logic [7:0] TMS_MEAS_BASE     = 8'h60;
   localparam logic [3:0] TMS_MEAS_BYTES    = 4'hA;
   localparam logic [7:0] TMS_ALARM_BASE    = 8'h70;
   localparam logic [7:0] TMS_WARN_BASE     = 8'h74;
   localparam logic [7:0] TMS_USER_BASE     = 8'h80;
   localparam logic [3:0] TMS_BYTE_BITS     = 4'h8;
   localparam logic [3:0] TMS_LAST_BIT      = 4'h7;

   // =====================================================================
   // monitor channels, high index first in the map
   localparam int         TMS_NUM_CH  = 5;
   localparam logic [2:0] TMS_CH_TEMP = 3'h4;
   localparam logic [2:0] TMS_CH_VCC  = 3'h3;
   localparam logic [2:0] TMS_CH_BIAS = 3'h2;
   localparam logic [2:0] TMS_CH_TXP  = 3'h1;
   localparam logic [2:0] TMS_CH_RXP  = 3'h0;

   // =====================================================================
   // timing
   localparam int TMS_CLK_PERIOD_NS = 10;
   localparam int TMS_TXDIS_MAX_US  = 10;
   localparam int TMS_TXDIS_MAX_CYC = (TMS_TXDIS_MAX_US * 1000)
                                      / TMS_CLK_PERIOD_NS;

   // =====================================================================
   // types
   typedef logic [TMS_NUM_CH-1:0][15:0] tms_chan_t;

   typedef struct packed {
      logic [15:0] temp;
      logic [15:0] vcc;
      logic [15:0] bias;
      logic [15:0] txpwr;
      logic [15:0] rxpwr;
   } tms_meas_s;

   typedef struct packed {
      tms_chan_t alarm_hi;
      tms_chan_t alarm_lo;
      tms_chan_t warn_hi;
      tms_chan_t warn_lo;
   } tms_lim_s;

   typedef struct packed {
      logic       en;
      logic       diag;
      logic [7:0] addr;
      logic [7:0] data;
   } tms_load_s;

   typedef enum {
      TMS_IDLE, TMS_DEVADDR, TMS_ACK, TMS_WORDADDR,
      TMS_WRITE, TMS_READ, TMS_RDACK
   } tms_state_e;

endpackage

// *** rtl/tms_mgmt_slave.sv ***
// tms_mgmt_slave: two-wire serial slave with id map, diagnostics map
// and transmitter/receiver status pins
// assumes serial and status input pins asynchronous to clk_sys_i; serial clock far slower
`timescale 1ns/1ns

module tms_mgmt_slave #(
   parameter int USER_BASE = 128
) (
   // clock and reset
   input  wire logic              clk_sys_i,
   input  wire logic              rst_n_i,
   // serial management pins
   input  wire logic              scl_i,
   input  wire logic              sda_i,
   output logic                   sda_o,
   output logic                   sda_oe_o,
   output logic                   mod_present_o,
   // transmitter and receiver status pins
   input  wire logic              tx_disable_in_i,
   input  wire logic              rx_sig_detect_i,
   output logic                   laser_en_o,
   output logic                   tx_fault_out_o,
   output logic                   rx_signal_lost_o,
   // monitor inputs and factory contents
   input  wire tms_pkg::tms_meas_s meas_i,
   input  wire tms_pkg::tms_lim_s  lim_i,
   input  wire tms_pkg::tms_load_s load_i
);
   import tms_pkg::*;

   if (USER_BASE < 0 || USER_BASE >= TMS_MAP_BYTES) begin : g_bad_base
      $error("USER_BASE outside the map");
   end

   localparam logic [7:0] USER_LO = 8'(USER_BASE);
   localparam int TXDIS_MAX = TMS_TXDIS_MAX_CYC;

   // =====================================================================
   // reset release and input synchronisers
   logic       rst_ff1_reg, rst_n;
   logic [3:0] pin_ff1_reg, pin_s_reg;
   logic       scl_d_reg, sda_d_reg;

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_ff1_reg <= 1'b0;
         rst_n       <= 1'b0;
      end else begin
         rst_ff1_reg <= 1'b1;
         rst_n       <= rst_ff1_reg;
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         pin_ff1_reg <= 4'hF;
         pin_s_reg   <= 4'hF;
         scl_d_reg   <= 1'b1;
         sda_d_reg   <= 1'b1;
      end else begin
         pin_ff1_reg <= {scl_i, sda_i, tx_disable_in_i, rx_sig_detect_i};
         pin_s_reg   <= pin_ff1_reg;
         scl_d_reg   <= pin_s_reg[3];
         sda_d_reg   <= pin_s_reg[2];
      end
   end

   logic scl_s, sda_s, tx_disable_in_s, sigdet_s;
   logic scl_rise, scl_fall, start_ev, stop_ev;
   assign {scl_s, sda_s, tx_disable_in_s, sigdet_s} = pin_s_reg;
   assign scl_rise = scl_s & ~scl_d_reg;
   assign scl_fall = ~scl_s & scl_d_reg;
   // framing seen only while clock high
   assign start_ev = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
   assign stop_ev  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

   // =====================================================================
   // monitor sampling and limit flags
   tms_chan_t meas_reg, meas_next;
   logic [2*TMS_NUM_CH-1:0] alarm_reg, alarm_next, warn_reg, warn_next;

   always_comb begin
      meas_next = tms_chan_t'(meas_i);
      for (int c = 0; c < TMS_NUM_CH; c++) begin
         alarm_next[2*c+1] = meas_reg[c] > lim_i.alarm_hi[c];
         alarm_next[2*c]   = meas_reg[c] < lim_i.alarm_lo[c];
         warn_next[2*c+1]  = meas_reg[c] > lim_i.warn_hi[c];
         warn_next[2*c]    = meas_reg[c] < lim_i.warn_lo[c];
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         meas_reg  <= '0;
         alarm_reg <= '0;
         warn_reg  <= '0;
      end else begin
         meas_reg  <= meas_next;
         alarm_reg <= alarm_next;
         warn_reg  <= warn_next;
      end
   end

   // =====================================================================
   // status pins
   logic laser_en_reg, fault_reg, los_reg, present_reg, sda_lvl_reg;
   logic laser_en_next, fault_next, los_next;

   always_comb begin
      laser_en_next = ~tx_disable_in_s;
      fault_next    = alarm_reg[2*TMS_CH_BIAS+1]
                    | alarm_reg[2*TMS_CH_TXP+1];
      los_next      = ~sigdet_s;
   end

   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         laser_en_reg <= 1'b0;
         fault_reg    <= 1'b0;
         los_reg      <= 1'b1;
         present_reg  <= 1'b0;
         sda_lvl_reg  <= 1'b0;
      end else begin
         laser_en_reg <= laser_en_next;
         fault_reg    <= fault_next;
         los_reg      <= los_next;
         present_reg  <= 1'b0;
         sda_lvl_reg  <= 1'b0;
      end
   end

   // =====================================================================
   // maps: id fully protected, diagnostics writable from USER_LO up
   logic [7:0] id_mem   [TMS_MAP_BYTES];
   logic [7:0] diag_mem [TMS_MAP_BYTES];
   tms_state_e state_reg, state_next, after_reg, after_next;
   logic [7:0] shift_reg, shift_next, addr_reg, addr_next, rd_byte;
   logic [3:0] bit_reg, bit_next;
   logic       diag_reg, diag_next, oe_reg, oe_next, nack_reg, nack_next;
   logic       host_we;
   logic [3:0] moff;
   logic [2:0] mch;

   assign host_we = (state_reg == TMS_WRITE) && scl_fall && !start_ev
                  && !stop_ev && (bit_reg == TMS_BYTE_BITS)
                  && diag_reg && (addr_reg >= USER_LO);

   always_ff @(posedge clk_sys_i) begin
      if (load_i.en && !load_i.diag)
         id_mem[load_i.addr] <= load_i.data;
      if (load_i.en && load_i.diag)
         diag_mem[load_i.addr] <= load_i.data;
      else if (host_we)
         diag_mem[addr_reg] <= shift_reg;
   end

   // read mux with live overlay
   always_comb begin
      moff = addr_reg[3:0] - TMS_MEAS_BASE[3:0];
      mch  = TMS_CH_TEMP - moff[3:1];
      if (!diag_reg)
         rd_byte = id_mem[addr_reg];
      else if (addr_reg[7:4] == TMS_MEAS_BASE[7:4]
               && moff < TMS_MEAS_BYTES)
         rd_byte = moff[0] ? meas_reg[mch][7:0]
                           : meas_reg[mch][15:8];
      else if (addr_reg == TMS_ALARM_BASE)
         rd_byte = alarm_reg[9:2];
      else if (addr_reg == TMS_ALARM_BASE + 8'h01)
         rd_byte = {alarm_reg[1:0], 6'h00};
      else if (addr_reg == TMS_WARN_BASE)
         rd_byte = warn_reg[9:2];
      else if (addr_reg == TMS_WARN_BASE + 8'h01)
         rd_byte = {warn_reg[1:0], 6'h00};
      else
         rd_byte = diag_mem[addr_reg];
   end

   // =====================================================================
   // serial protocol engine
   always_comb begin
      state_next = state_reg;
      after_next = after_reg;
      shift_next = shift_reg;
      addr_next  = addr_reg;
      bit_next   = bit_reg;
      diag_next  = diag_reg;
      oe_next    = oe_reg;
      nack_next  = nack_reg;
      if (start_ev) begin
         state_next = TMS_DEVADDR;
         bit_next   = 4'h0;
         oe_next    = 1'b0;
      end else if (stop_ev) begin
         state_next = TMS_IDLE;
         oe_next    = 1'b0;
      end else begin
         case (state_reg)
            TMS_DEVADDR, TMS_WORDADDR, TMS_WRITE: begin
               if (scl_rise && bit_reg < TMS_BYTE_BITS) begin
                  shift_next = {shift_reg[6:0], sda_s};
                  bit_next   = bit_reg + 4'h1;
               end else if (scl_fall && bit_reg == TMS_BYTE_BITS) begin
                  oe_next    = 1'b1;
                  state_next = TMS_ACK;
                  after_next = TMS_WRITE;
                  if (state_reg == TMS_DEVADDR) begin
                     diag_next  = shift_reg[7:1] == TMS_DIAG_DEV_ADDR;
                     after_next = shift_reg[0] ? TMS_READ : TMS_WORDADDR;
                     if (shift_reg[7:1] != TMS_ID_DEV_ADDR
                         && shift_reg[7:1] != TMS_DIAG_DEV_ADDR) begin
                        oe_next    = 1'b0;
                        state_next = TMS_IDLE;
                     end
                  end else if (state_reg == TMS_WORDADDR)
                     addr_next = shift_reg;
                  else
                     addr_next = addr_reg + 8'h01;
               end
            end
            TMS_ACK: begin
               if (scl_fall) begin
                  bit_next   = 4'h0;
                  state_next = after_reg;
                  oe_next    = 1'b0;
                  if (after_reg == TMS_READ) begin
                     shift_next = rd_byte;
                     oe_next    = ~rd_byte[7];
                  end
               end
            end
            TMS_READ: begin
               if (scl_fall) begin
                  if (bit_reg == TMS_LAST_BIT) begin
                     oe_next    = 1'b0;
                     state_next = TMS_RDACK;
                     addr_next  = addr_reg + 8'h01;
                  end else begin
                     shift_next = {shift_reg[6:0], 1'b0};
                     oe_next    = ~shift_reg[6];
                     bit_next   = bit_reg + 4'h1;
                  end
               end
            end
            TMS_RDACK: begin
               if (scl_rise)
                  nack_next = sda_s;
               else if (scl_fall) begin
                  if (nack_reg)
                     state_next = TMS_IDLE;
                  else begin
                     state_next = TMS_READ;
                     bit_next   = 4'h0;
                     shift_next = rd_byte;
                     oe_next    = ~rd_byte[7];
                  end
               end
            end
            default: begin
               oe_next = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= TMS_IDLE;
         after_reg <= TMS_IDLE;
         shift_reg <= 8'h00;
         addr_reg  <= 8'h00;
         bit_reg   <= 4'h0;
         diag_reg  <= 1'b0;
         oe_reg    <= 1'b0;
         nack_reg  <= 1'b1;
      end else begin
         state_reg <= state_next;
         after_reg <= after_next;
         shift_reg <= shift_next;
         addr_reg  <= addr_next;
         bit_reg   <= bit_next;
         diag_reg  <= diag_next;
         oe_reg    <= oe_next;
         nack_reg  <= nack_next;
      end
   end

   assign sda_o            = sda_lvl_reg;
   assign sda_oe_o         = oe_reg;
   assign mod_present_o    = present_reg;
   assign laser_en_o       = laser_en_reg;
   assign tx_fault_out_o   = fault_reg;
   assign rx_signal_lost_o = los_reg;

   // =====================================================================
   // assertions
   sequence s_addr_done;
      state_reg == TMS_DEVADDR && scl_fall && !start_ev && !stop_ev
      && bit_reg == TMS_BYTE_BITS;
   endsequence

   sequence s_byte_out;
      state_reg == TMS_READ && scl_fall && !start_ev && !stop_ev
      && bit_reg == TMS_LAST_BIT;
   endsequence

   property p_id_ack;
      @(posedge clk_sys_i) disable iff (!rst_n)
      s_addr_done and shift_reg[7:1] == TMS_ID_DEV_ADDR
      |=> oe_reg && !diag_reg && state_reg == TMS_ACK;
   endproperty
   a_id_ack: assert property (p_id_ack) else $error("id ack");

   property p_diag_ack;
      @(posedge clk_sys_i) disable iff (!rst_n)
      s_addr_done and shift_reg[7:1] == TMS_DIAG_DEV_ADDR
      |=> oe_reg && diag_reg && state_reg == TMS_ACK;
   endproperty
   a_diag_ack: assert property (p_diag_ack) else $error("diag ack");

   property p_foreign;
      @(posedge clk_sys_i) disable iff (!rst_n)
      s_addr_done and shift_reg[7:2] != TMS_ID_DEV_ADDR[6:1]
      |=> !oe_reg && state_reg == TMS_IDLE;
   endproperty
   a_foreign: assert property (p_foreign) else $error("foreign ack");

   property p_oe_on_fall;
      @(posedge clk_sys_i) disable iff (!rst_n)
      $changed(oe_reg) |-> $past(scl_fall || start_ev || stop_ev);
   endproperty
   a_oe_on_fall: assert property (p_oe_on_fall) else $error("oe edge");

   property p_protect;
      @(posedge clk_sys_i) disable iff (!rst_n)
      !load_i.en && (!diag_reg || addr_reg < USER_LO)
      |=> diag_mem[$past(addr_reg)] == $past(diag_mem[addr_reg]);
   endproperty
   a_protect: assert property (p_protect) else $error("protected");

   property p_wrap;
      @(posedge clk_sys_i) disable iff (!rst_n)
      s_byte_out |=> addr_reg == 8'($past(addr_reg) + 8'h01)
                     && !oe_reg && state_reg == TMS_RDACK;
   endproperty
   a_wrap: assert property (p_wrap) else $error("address step");

   property p_los;
      @(posedge clk_sys_i) disable iff (!rst_n)
      rx_sig_detect_i [*4] |=> !rx_signal_lost_o;
   endproperty
   a_los: assert property (p_los) else $error("los level");

   property p_txdis_time;
      @(posedge clk_sys_i) disable iff (!rst_n)
      tx_disable_in_i [*4] |-> ##[0:TXDIS_MAX] !laser_en_o;
   endproperty
   a_txdis_time: assert property (p_txdis_time) else $error("tx off");

   property p_txen_low;
      @(posedge clk_sys_i) disable iff (!rst_n)
      laser_en_o |-> !$past(tx_disable_in_i, 3);
   endproperty
   a_txen_low: assert property (p_txen_low) else $error("tx on");

   property p_fault;
      @(posedge clk_sys_i) disable iff (!rst_n)
      meas_reg[TMS_CH_BIAS] > lim_i.alarm_hi[TMS_CH_BIAS] && $stable(lim_i)
      |=> ##1 tx_fault_out_o;
   endproperty
   a_fault: assert property (p_fault) else $error("fault pin");

   property p_flag;
      @(posedge clk_sys_i) disable iff (!rst_n)
      meas_reg[TMS_CH_TEMP] < lim_i.warn_lo[TMS_CH_TEMP]
      |=> warn_reg[2*TMS_CH_TEMP];
   endproperty
   a_flag: assert property (p_flag) else $error("warn flag");

endmodule

// *** test/tms_host_model.sv ***
// tms_host_model: behavioural two-wire host for the management slave
// assumes the bench resolves the pulled-up data wire from both drivers
`timescale 1ns/1ns
module tms_host_model (
   // serial pins
   output logic      scl_o,
   output logic      sda_low_o,
   input  wire logic sda_wire_i
);
   // a quarter of the 125 ns link period, last quarter one longer
   localparam int Q = 31;

   initial begin
      scl_o = 1'b1;
      sda_low_o = 1'b0;
   end

   // =====================================================================
   // bit level: data moves only while the clock is low
   task automatic bit_cycle(input logic b, output logic got);
      sda_low_o = ~b;
      #Q scl_o = 1'b1;
      #Q got = sda_wire_i;
      #Q if (sda_wire_i !== got) got = 1'bx;
      scl_o = 1'b0;
      #(Q + 1);
   endtask

   // =====================================================================
   // framing and bytes
   task automatic start_cond();
      sda_low_o = 1'b0;
      #Q scl_o = 1'b1;
      #Q sda_low_o = 1'b1;
      #Q scl_o = 1'b0;
      #Q;
   endtask

   task automatic stop_cond();
      sda_low_o = 1'b1;
      #Q scl_o = 1'b1;
      #Q sda_low_o = 1'b0;
      #Q;
   endtask

   task automatic wr_byte(input logic [7:0] d, output logic ack);
      logic g;
      for (int i = 7; i >= 0; i--) bit_cycle(d[i], g);
      bit_cycle(1'b1, g);
      ack = ~g;
   endtask

   task automatic rd_byte(input logic last, output logic [7:0] d);
      logic g;
      for (int i = 7; i >= 0; i--) begin
         bit_cycle(1'b1, g);
         d[i] = g;
      end
      bit_cycle(last, g);
   endtask
endmodule

// *** test/transceiver_mgmt_serial_slave_tb_top.sv ***
// transceiver_mgmt_serial_slave_tb_top: self-checking bench of the
// management slave against a behavioural map model
// assumes tms_pkg, tms_mgmt_slave and tms_host_model compiled first
`timescale 1ns/1ns
module transceiver_mgmt_serial_slave_tb_top;
   import tms_pkg::*;

   // =====================================================================
   // signals and model state
   logic        clk_sys_i, rst_n_i, tx_disable_in_i, rx_sig_detect_i;
   logic        scl_w, host_low, sda_w, sda_o, sda_oe_o, mod_present_o;
   logic        laser_en_o, tx_fault_out_o, rx_signal_lost_o;
   tms_meas_s   meas_i;
   tms_lim_s    lim_i;
   tms_load_s   load_i;
   logic [7:0]  idm [256];
   logic [7:0]  dgm [256];
   logic [31:0] rng;
   int          n_mismatch, compares;

   // released wire rises to the pull-up level
   assign sda_w = ~(sda_oe_o | host_low);

   tms_mgmt_slave tms_mgmt_slave_inst (
      .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .scl_i(scl_w),
      .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
      .mod_present_o(mod_present_o), .tx_disable_in_i(tx_disable_in_i),
      .rx_sig_detect_i(rx_sig_detect_i), .laser_en_o(laser_en_o),
      .tx_fault_out_o(tx_fault_out_o),
      .rx_signal_lost_o(rx_signal_lost_o), .meas_i(meas_i),
      .lim_i(lim_i), .load_i(load_i));

   tms_host_model host_model_inst (
      .scl_o(scl_w), .sda_low_o(host_low), .sda_wire_i(sda_w));

   initial begin
      clk_sys_i = 1'b0;
      forever #5 clk_sys_i = ~clk_sys_i;
   end

   // =====================================================================
   // helpers
   function automatic logic [31:0] rnd();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
      return rng;
   endfunction

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic give_verdict();
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   function automatic logic [7:0] flag_byte(input tms_chan_t hi,
                                            input tms_chan_t lo,
                                            input bit rx);
      logic [7:0] f;
      int         b;
      f = 8'h00;
      for (int c = 0; c < TMS_NUM_CH; c++) begin
         b = rx ? 7 : 2 * c - 1;
         if ((c == 0) == rx) begin
            f[b] = meas_i[c*16 +: 16] > hi[c];
            f[b-1] = meas_i[c*16 +: 16] < lo[c];
         end
      end
      return f;
   endfunction

   function automatic logic [7:0] exp_byte(input bit dg,
                                           input logic [7:0] a);
      int o;
      o = 79 - 8 * int'(a - TMS_MEAS_BASE);
      if (!dg) return idm[a];
      if (a >= TMS_MEAS_BASE && a < TMS_MEAS_BASE + 8'h0A)
         return meas_i[o -: 8];
      case (a)
         TMS_ALARM_BASE:
            return flag_byte(lim_i.alarm_hi, lim_i.alarm_lo, 1'b0);
         TMS_ALARM_BASE + 8'h01:
            return flag_byte(lim_i.alarm_hi, lim_i.alarm_lo, 1'b1);
         TMS_WARN_BASE:
            return flag_byte(lim_i.warn_hi, lim_i.warn_lo, 1'b0);
         TMS_WARN_BASE + 8'h01:
            return flag_byte(lim_i.warn_hi, lim_i.warn_lo, 1'b1);
         default: return dgm[a];
      endcase
   endfunction

   task automatic set_ptr(input logic [6:0] dev, input logic [7:0] a);
      logic ack;
      host_model_inst.start_cond();
      host_model_inst.wr_byte({dev, 1'b0}, ack);
      check(ack, 1'b1);
      host_model_inst.wr_byte(a, ack);
      check(ack, 1'b1);
   endtask

   task automatic rd_chk(input logic [6:0] dev, input logic [7:0] a,
                         input int n);
      logic       ack;
      logic [7:0] d;
      set_ptr(dev, a);
      host_model_inst.start_cond();
      host_model_inst.wr_byte({dev, 1'b1}, ack);
      check(ack, 1'b1);
      for (int i = 0; i < n; i++) begin
         host_model_inst.rd_byte(i == n - 1, d);
         check(d, exp_byte(dev == TMS_DIAG_DEV_ADDR, a + 8'(i)));
      end
      host_model_inst.stop_cond();
   endtask

   task automatic wr_seq(input logic [6:0] dev, input logic [7:0] a,
                         input int n);
      logic       ack;
      logic [7:0] d, ai;
      set_ptr(dev, a);
      for (int i = 0; i < n; i++) begin
         d = 8'(rnd());
         ai = a + 8'(i);
         host_model_inst.wr_byte(d, ack);
         check(ack, 1'b1);
         if (dev == TMS_DIAG_DEV_ADDR && ai >= TMS_USER_BASE) dgm[ai] = d;
      end
      host_model_inst.stop_cond();
   endtask

   // =====================================================================
   // scenarios
   initial begin
      logic         ack;
      logic [7:0]   d;
      logic [319:0] w;
      n_mismatch = 0;
      compares = 0;
      rng = 32'h39;
      rst_n_i <= 1'b0;
      tx_disable_in_i <= 1'b1;
      rx_sig_detect_i <= 1'b1;
      load_i <= '0;
      meas_i <= '0;
      lim_i <= '0;
      repeat (2) @(posedge clk_sys_i);
      check(rx_signal_lost_o, 1'b1);
      check(sda_oe_o, 1'b0);
      rst_n_i <= 1'b1;
      for (int i = 0; i < 512; i++) begin
         d = 8'(rnd());
         load_i <= '{1'b1, i[8], i[7:0], d};
         if (i[8]) dgm[i[7:0]] = d;
         else idm[i[7:0]] = d;
         @(posedge clk_sys_i);
      end
      load_i <= '0;
      check(mod_present_o, 1'b0);
      check(laser_en_o, 1'b0);
      $display("test reset_and_load done");
      rd_chk(TMS_ID_DEV_ADDR, 8'hFE, 4);
      wr_seq(TMS_ID_DEV_ADDR, 8'h10, 2);
      rd_chk(TMS_ID_DEV_ADDR, 8'h10, 2);
      wr_seq(TMS_DIAG_DEV_ADDR, 8'hFF, 2);
      wr_seq(TMS_DIAG_DEV_ADDR, 8'h80, 3);
      rd_chk(TMS_DIAG_DEV_ADDR, 8'hFF, 5);
      rd_chk(TMS_DIAG_DEV_ADDR, 8'h7E, 4);
      host_model_inst.start_cond();
      host_model_inst.wr_byte(8'hA4, ack);
      check(ack, 1'b0);
      host_model_inst.stop_cond();
      $display("test maps done");
      for (int r = 0; r < 4; r++) begin
         @(posedge clk_sys_i);
         for (int k = 0; k < 10; k++) w[k*32 +: 32] = rnd();
         lim_i <= w;
         meas_i <= {rnd(), rnd(), 16'(rnd())};
         repeat (4) @(posedge clk_sys_i);
         check(tx_fault_out_o, meas_i.bias > lim_i.alarm_hi[TMS_CH_BIAS]
               || meas_i.txpwr > lim_i.alarm_hi[TMS_CH_TXP]);
         rd_chk(TMS_DIAG_DEV_ADDR, TMS_MEAS_BASE, 10);
         rd_chk(TMS_DIAG_DEV_ADDR, TMS_ALARM_BASE, 2);
         rd_chk(TMS_DIAG_DEV_ADDR, TMS_WARN_BASE, 2);
      end
      $display("test diagnostics done");
      @(posedge clk_sys_i);
      tx_disable_in_i <= 1'b0;
      rx_sig_detect_i <= 1'b0;
      repeat (5) @(posedge clk_sys_i);
      check(laser_en_o, 1'b1);
      check(rx_signal_lost_o, 1'b1);
      tx_disable_in_i <= 1'b1;
      rx_sig_detect_i <= 1'b1;
      for (int n = 0; n < TMS_TXDIS_MAX_CYC && laser_en_o !== 1'b0; n++)
         @(posedge clk_sys_i);
      check(laser_en_o, 1'b0);
      repeat (5) @(posedge clk_sys_i);
      check(rx_signal_lost_o, 1'b0);
      check(sda_o, 1'b0);
      $display("test status_pins done");
      give_verdict();
   end

   // hang guard, several times the expected run
   initial begin
      #600000;
      n_mismatch++;
      give_verdict();
   end
endmodule
